// >>> slb_defines.vh
// Purpose: Constants for the scan line input buffer.
// Assumes: 20 MHz system clock, synchronous active-low reset.
// Notes:   Included by every design file of the block.
`ifndef SLB_DEFINES_VH
`define SLB_DEFINES_VH

// ****************************************************************
// Geometry
// ****************************************************************
`define SLB_WORD_W     8
`define SLB_DEPTH      1024
`define SLB_PTR_W      10
`define SLB_PTR_RST    10'h000
`define SLB_PTR_ONE    10'h001

// ****************************************************************
// Timing
// ****************************************************************
`define SLB_CLK_HZ     20000000
`define SLB_CONV_NS    40000
`define SLB_CONV_CYC   ((`SLB_CONV_NS * (`SLB_CLK_HZ / 1000000) + 999) / 1000)
`define SLB_CONV_LAST  10'h31F
`define SLB_CNT_W      10
`define SLB_CNT_RST    10'h000
`define SLB_CNT_ONE    10'h001

// ****************************************************************
// Reset values
// ****************************************************************
`define SLB_WORD_RST   8'h00
`define SLB_SYNC_RST   2'h0

`endif

// >>> slb_line_mem.v
// Purpose: One 1024-word by 8-bit line memory that behaves as a shift register.
// Assumes: Shift strobes are one clock wide.
// Notes:   A circular index stands in for physical shifting.
`include "slb_defines.vh"

module slb_line_mem
(
  // Clock and reset.
  input  wire                    clk_i,
  input  wire                    reset_n_i,
  // Shift control.
  input  wire                    shift_i,
  input  wire                    recirc_i,
  // Data.
  input  wire [`SLB_WORD_W-1:0]  data_i,
  output wire [`SLB_WORD_W-1:0]  data_o
);

  reg [`SLB_WORD_W-1:0] mem_r [0:`SLB_DEPTH-1];
  reg [`SLB_PTR_W-1:0]  ptr_r;

  // ****************************************************************
  // Storage
  // ****************************************************************
  // The stage at the index is the oldest word; it leaves as the new word enters.
  assign data_o = mem_r[ptr_r];

  always @(posedge clk_i)
  begin
    if (shift_i)
    begin
      if (recirc_i)
        mem_r[ptr_r] <= mem_r[ptr_r];
      else
        mem_r[ptr_r] <= data_i;
    end
  end

  // Only the index is reset; contents are overwritten by the next line.
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
      ptr_r <= `SLB_PTR_RST;
    else if (shift_i)
      ptr_r <= ptr_r + `SLB_PTR_ONE;
  end

endmodule

// >>> slb_top.v
// Purpose: Line memory input stage with input buffer and two output buffers.
// Assumes: Load, transfer and dump pulses and the sampler word arrive from pins.
// Notes:   Transfer and load never coincide; load is taken if they do.
`include "slb_defines.vh"

module slb_top
(
  // Clock and reset.
  input  wire                    clk_i,
  input  wire                    reset_n_i,
  // Pulse trains from the timing logic.
  input  wire                    load_pulse_i,
  input  wire                    xfer_pulse_i,
  input  wire                    dump_pulse_i,
  // Standby select, high picks output buffer zero as standby.
  input  wire                    standby_sel_i,
  // Sampler interface.
  input  wire [`SLB_WORD_W-1:0]  adc_data_i,
  output reg                     conv_start_o,
  // Reconstruction converter interface.
  output reg  [`SLB_WORD_W-1:0]  dac_data_o,
  // Status.
  output reg                     conv_busy_o
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function rise;
    input prev;
    input cur;
    begin
      rise = cur & ~prev;
    end
  endfunction

  // ****************************************************************
  // Synchronizers
  // ****************************************************************
  reg [1:0]             load_sync_r;
  reg [1:0]             xfer_sync_r;
  reg [1:0]             dump_sync_r;
  reg [1:0]             sel_sync_r;
  reg                   load_prev_r;
  reg                   xfer_prev_r;
  reg                   dump_prev_r;
  reg [`SLB_WORD_W-1:0] adc_meta_r;
  reg [`SLB_WORD_W-1:0] adc_sync_r;

  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      load_sync_r <= `SLB_SYNC_RST;
      xfer_sync_r <= `SLB_SYNC_RST;
      dump_sync_r <= `SLB_SYNC_RST;
      sel_sync_r  <= `SLB_SYNC_RST;
      load_prev_r <= 1'b0;
      xfer_prev_r <= 1'b0;
      dump_prev_r <= 1'b0;
      adc_meta_r  <= `SLB_WORD_RST;
      adc_sync_r  <= `SLB_WORD_RST;
    end
    else
    begin
      load_sync_r <= {load_sync_r[0], load_pulse_i};
      xfer_sync_r <= {xfer_sync_r[0], xfer_pulse_i};
      dump_sync_r <= {dump_sync_r[0], dump_pulse_i};
      sel_sync_r  <= {sel_sync_r[0], standby_sel_i};
      load_prev_r <= load_sync_r[1];
      xfer_prev_r <= xfer_sync_r[1];
      dump_prev_r <= dump_sync_r[1];
      adc_meta_r  <= adc_data_i;
      adc_sync_r  <= adc_meta_r;
    end
  end

  // ****************************************************************
  // Shift strobes
  // ****************************************************************
  wire load_stb;
  wire xfer_stb;
  wire dump_stb;

  assign load_stb = rise(load_prev_r, load_sync_r[1]);
  assign xfer_stb = rise(xfer_prev_r, xfer_sync_r[1]) & ~load_stb;
  assign dump_stb = rise(dump_prev_r, dump_sync_r[1]);

  // ****************************************************************
  // Conversion timer
  // ****************************************************************
  reg [1:0]             state_r;
  reg [1:0]             state_nxt;
  reg [`SLB_CNT_W-1:0]  cnt_r;
  reg [`SLB_CNT_W-1:0]  cnt_nxt;
  reg [`SLB_WORD_W-1:0] sample_r;
  wire                  conv_done;

  assign conv_done = (state_r == ST_CONV) &&
                     (cnt_r == `SLB_CONV_LAST);

  always @*
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_IDLE:
      begin
        if (load_stb)
        begin
          state_nxt = ST_CONV;
          cnt_nxt   = `SLB_CNT_RST;
        end
      end
      ST_CONV:
      begin
        if (load_stb)
          cnt_nxt = `SLB_CNT_RST;
        else if (conv_done)
          state_nxt = ST_IDLE;
        else
          cnt_nxt = cnt_r + `SLB_CNT_ONE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
        cnt_nxt   = `SLB_CNT_RST;
      end
    endcase
  end

  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state_r      <= ST_IDLE;
      cnt_r        <= `SLB_CNT_RST;
      sample_r     <= `SLB_WORD_RST;
      conv_start_o <= 1'b0;
      conv_busy_o  <= 1'b0;
    end
    else
    begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      conv_start_o <= load_stb;
      conv_busy_o  <= (state_nxt == ST_CONV);
      if (conv_done && !load_stb)
        sample_r <= adc_sync_r;
    end
  end

  // ****************************************************************
  // Input buffer
  // ****************************************************************
  wire                  in_shift;
  wire [`SLB_WORD_W-1:0] in_out;

  // Always enabled; either pulse train advances it, dump never gates it.
  assign in_shift = load_stb | xfer_stb;

  slb_line_mem u_in_buf
  (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .shift_i   (in_shift),
    .recirc_i  (1'b0),
    .data_i    (sample_r),
    .data_o    (in_out)
  );

  // ****************************************************************
  // Output buffers
  // ****************************************************************
  wire [1:0]             standby;
  wire [`SLB_WORD_W-1:0] out_word [0:1];

  assign standby = {~sel_sync_r[1], sel_sync_r[1]};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_out
      wire ob_shift;
      assign ob_shift = standby[gi] ? xfer_stb : dump_stb;
      slb_line_mem u_out_buf
      (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .shift_i   (ob_shift),
        .recirc_i  (~standby[gi]),
        .data_i    (in_out),
        .data_o    (out_word[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Dump select
  // ****************************************************************
  wire                   dump_sel;
  wire [`SLB_WORD_W-1:0] dump_word;

  // The buffer that is not on standby feeds the reconstruction converter.
  assign dump_sel  = standby[0];
  assign dump_word = dump_sel ? out_word[1] : out_word[0];

  // ****************************************************************
  // Output register
  // ****************************************************************
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
      dac_data_o <= `SLB_WORD_RST;
    else if (dump_stb)
      dac_data_o <= dump_word;
  end

endmodule

// >>> slb_top_chk.sv
// Purpose: Port checker for slb_top.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to every slb_top instance.
`include "slb_defines.vh"
module slb_top_chk
(
  // Clock and reset.
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  // Pulses and select.
  input wire logic       load_pulse_i,
  input wire logic       xfer_pulse_i,
  input wire logic       dump_pulse_i,
  input wire logic       standby_sel_i,
  // Converters.
  input wire logic [7:0] adc_data_i,
  input wire logic       conv_start_o,
  input wire logic [7:0] dac_data_o,
  input wire logic       conv_busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] cnt_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Counts cycles of the running conversion timer.
  always @(posedge clk_i)
    cnt_r <= conv_start_o ? 12'h001 : (conv_busy_o ? cnt_r + 12'h001 : cnt_r);
  sequence s_load;
    $rose(load_pulse_i);
  endsequence
  sequence s_start;
    conv_start_o ##1 !conv_start_o;
  endsequence
  a_start_on_load: assert property (s_load |-> ##[2:5] s_start) else $error("no start after load");
  a_start_cause: assert property ($rose(conv_start_o) |-> $past(load_pulse_i, 3)) else $error("stray start");
  a_start_one: assert property (conv_start_o |=> !conv_start_o) else $error("start too long");
  a_busy_start: assert property (conv_start_o |-> conv_busy_o) else $error("busy missing");
  a_busy_rise: assert property ($rose(conv_busy_o) |-> conv_start_o) else $error("busy rise");
  a_conv_len: assert property ($fell(conv_busy_o) |-> cnt_r == `SLB_CONV_CYC) else $error("bad length");
  a_reset_quiet: assert property ($rose(reset_n_i) |-> !conv_start_o && !conv_busy_o
    && dac_data_o == 8'h00) else $error("reset values");
  a_dac_cause: assert property ($changed(dac_data_o) |-> $past(dump_pulse_i, 3)) else $error("dac moved");
endmodule
bind slb_top slb_top_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .load_pulse_i(load_pulse_i),
  .xfer_pulse_i(xfer_pulse_i), .dump_pulse_i(dump_pulse_i), .standby_sel_i(standby_sel_i),
  .adc_data_i(adc_data_i), .conv_start_o(conv_start_o), .dac_data_o(dac_data_o), .conv_busy_o(conv_busy_o));

// >>> slb_conv_model.sv
// Purpose: Sampler model giving one word per conversion start.
// Assumes: Word is valid only after the conversion time.
// Notes:   Shows the inverted word while converting.
module slb_conv_model
(
  // Clock.
  input  wire logic       clk_i,
  // Conversion control and word.
  input  wire logic       conv_start_i,
  input  wire logic [7:0] value_i,
  output logic      [7:0] adc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  always @(posedge clk_i)
  begin
    if (conv_start_i)
      cnt <= 1;
    else if (cnt != 0 && cnt < 790)
      cnt <= cnt + 1;
    adc_o <= (cnt >= 790) ? value_i : ~value_i;
  end
endmodule

// >>> tb.sv
// Purpose: Self-checking bench for slb_top.
// Assumes: Inputs change at the falling clock edge.
// Notes:   Pulses are three cycles high, four low.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic [2:0] pv = 3'h0;
  logic       sel = 1'b1;
  logic [7:0] val = 8'hA5;
  logic [7:0] adc;
  wire        start;
  wire        busy;
  wire  [7:0] dac;
  int         error_cnt = 0;
  int         n_checks = 0;
  always #25 clk_i = ~clk_i;
  slb_top DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .load_pulse_i(pv[0]), .xfer_pulse_i(pv[1]),
    .dump_pulse_i(pv[2]), .standby_sel_i(sel), .adc_data_i(adc), .conv_start_o(start),
    .dac_data_o(dac), .conv_busy_o(busy));
  slb_conv_model u_adc (.clk_i(clk_i), .conv_start_i(start), .value_i(val), .adc_o(adc));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task pulse(input logic [2:0] m);
    @(negedge clk_i);
    pv = m;
    repeat (3) @(negedge clk_i);
    pv = 3'h0;
    repeat (3) @(negedge clk_i);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset;
    repeat (16) @(negedge clk_i);
    chk({6'h00, start, busy}, 8'h00);
    chk(dac, 8'h00);
    reset_n_i = 1'b1;
  endtask
  task wait_idle;
    int i;
    for (i = 0; i < 1000 && busy !== 1'b0; i++)
      @(negedge clk_i);
    if (i == 1000)
    begin
      error_cnt++;
      $display("[FAIL] %0t conversion never ended", $time);
      final_report;
    end
  endtask
  task t_load;
    pulse(3'h1);
    chk({7'h00, busy}, 8'h01);
    wait_idle;
  endtask
  task t_fill;
    repeat (1024) pulse(3'h2);
    repeat (1024) pulse(3'h6);
    @(negedge clk_i);
    sel = 1'b0;
    repeat (2)
    begin
      pulse(3'h4);
      chk(dac, 8'hA5);
    end
    chk({7'h00, busy}, 8'h00);
  endtask
  // Input line is all A5; a new sample then follows it through the input buffer and output buffer one in order.
  task t_order;
    int i;
    val = 8'h3C;
    pulse(3'h1);
    chk({7'h00, busy}, 8'h01);
    wait_idle;
    repeat (1536) pulse(3'h2);
    @(negedge clk_i);
    sel = 1'b1;
    for (i = 0; i < 1024; i++)
    begin
      pulse(3'h4);
      chk(dac, (i < 512) ? 8'hA5 : 8'h3C);
    end
  endtask
  initial
  begin
    t_reset;
    t_load;
    t_fill;
    t_order;
    final_report;
  end
endmodule
